// file: logic/fdc_cmd_seq.sv
// command, execution and result sequencer for id readback, verify, version and writes
// assumes host and drive-side logic run on i_sys_clk; no synchronisers are needed
`timescale 1ns/1ps
`default_nettype none
module fdc_cmd_seq (
    input  wire logic                   i_sys_clk,
    input  wire logic                   i_reset,
    // host command bytes
    input  wire logic                   i_cmd_valid,
    input  wire logic [7:0]             i_cmd_byte,
    output logic                        o_cmd_ready,
    // host result bytes
    output logic                        o_res_valid,
    output logic      [7:0]             o_res_byte,
    input  wire logic                   i_res_ready,
    // host write data
    input  wire logic                   i_wr_valid,
    input  wire logic [7:0]             i_wr_byte,
    output logic                        o_wr_ready,
    // execution request toward the drive engine
    output logic                        o_exec_start,
    output logic                        o_exec_busy,
    output fdc_cmd_pkg::cmd_kind_t      o_exec_kind,
    output logic                        o_multitrack_flag,
    output logic                        o_double_density_flag,
    output logic                        o_skip_deleted_flag,
    output logic                        o_count_enable_flag,
    output logic                        o_deleted_mark,
    output logic                        o_head_select,
    output logic                        o_drive_num_hi,
    output logic                        o_drive_num_lo,
    output logic      [7:0]             o_cylinder,
    output logic      [7:0]             o_head_addr,
    output logic      [7:0]             o_record,
    output logic      [7:0]             o_size_code,
    output logic      [7:0]             o_last_sector_number,
    output logic      [7:0]             o_gap_length_param,
    output logic      [7:0]             o_data_length_param,
    output logic                        o_host_data_en,
    // write data toward the floppy_drive
    output logic                        o_drv_wr_valid,
    output logic      [7:0]             o_drv_wr_byte,
    input  wire logic                   i_drv_wr_ready,
    // completion from the drive engine
    input  wire logic                   i_exec_done,
    input  wire logic [7:0]             i_result_status_a,
    input  wire logic [7:0]             i_result_status_b,
    input  wire logic [7:0]             i_result_status_c,
    input  wire logic [7:0]             i_end_cylinder,
    input  wire logic [7:0]             i_end_head,
    input  wire logic [7:0]             i_end_record,
    input  wire logic [7:0]             i_end_size_code,
    // status
    output logic                        o_cmd_invalid
);
    fdc_cmd_pkg::seq_state_t state_q;
    fdc_cmd_pkg::seq_state_t state_d;
    fdc_cmd_pkg::cmd_kind_t  kind_q;
    fdc_cmd_pkg::cmd_kind_t  dec_kind;
    logic [3:0]              dec_prm_len;
    logic [7:0]              op_q;
    logic [7:0]              prm_q [0:7];
    logic [3:0]              prm_len_q;
    logic [3:0]              prm_idx_q;
    logic [7:0]              res_q [0:6];
    logic [2:0]              res_len_q;
    logic [2:0]              res_idx_q;
    logic                    start_q;
    logic                    invalid_q;

    fdc_opcode_decode u_decode (
        .i_opcode  (i_cmd_byte),
        .o_kind    (dec_kind),
        .o_prm_len (dec_prm_len)
    );

    wire logic cmd_take   = i_cmd_valid && o_cmd_ready;
    wire logic res_take   = o_res_valid && i_res_ready;
    wire logic in_idle    = (state_q == fdc_cmd_pkg::ST_IDLE);
    wire logic in_param   = (state_q == fdc_cmd_pkg::ST_PARAM);
    wire logic in_exec    = (state_q == fdc_cmd_pkg::ST_EXEC);
    wire logic last_prm   = in_param && cmd_take && (prm_idx_q == prm_len_q - 4'h1);
    wire logic last_res   = res_take && (res_idx_q == res_len_q - 3'h1);
    wire logic op_taken   = in_idle && cmd_take;
    wire logic op_bad     = op_taken && (dec_kind == fdc_cmd_pkg::KIND_NONE);
    wire logic op_version = op_taken && (dec_kind == fdc_cmd_pkg::KIND_VERSION);
    // reserved drive bits set: refuse rather than guess which drive was meant
    wire logic drv_bad    = in_param && cmd_take && (prm_idx_q == 4'h0) &&
                            ((i_cmd_byte & fdc_cmd_pkg::DRV_RSVD_MASK) != 8'h00);   // see R9
    wire logic is_write   = (kind_q == fdc_cmd_pkg::KIND_WRITE) ||
                            (kind_q == fdc_cmd_pkg::KIND_WRITE_DEL);
    // verify and id readback never open the host data path
    wire logic data_path  = in_exec && is_write;                                     // see R4
    wire logic done_take  = in_exec && i_exec_done;

    // count-enable only exists in the verify drive byte
    wire logic cnt_en_sel = (kind_q == fdc_cmd_pkg::KIND_VERIFY) &&
                            prm_q[0][fdc_cmd_pkg::BIT_COUNT_EN];                     // see R3

    always_comb begin
        state_d = state_q;
        case (state_q)
            fdc_cmd_pkg::ST_IDLE: begin
                if (op_bad || op_version) begin
                    state_d = fdc_cmd_pkg::ST_RESULT;
                end else if (op_taken) begin
                    state_d = fdc_cmd_pkg::ST_PARAM;
                end
            end
            fdc_cmd_pkg::ST_PARAM: begin
                if (drv_bad) begin
                    state_d = fdc_cmd_pkg::ST_RESULT;
                end else if (last_prm) begin
                    state_d = fdc_cmd_pkg::ST_START;
                end
            end
            fdc_cmd_pkg::ST_START: begin
                state_d = fdc_cmd_pkg::ST_EXEC;
            end
            fdc_cmd_pkg::ST_EXEC: begin
                if (i_exec_done) begin
                    state_d = fdc_cmd_pkg::ST_RESULT;
                end
            end
            fdc_cmd_pkg::ST_RESULT: begin
                if (last_res) begin
                    state_d = fdc_cmd_pkg::ST_IDLE;
                end
            end
            default: begin
                state_d = fdc_cmd_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            state_q <= fdc_cmd_pkg::ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            kind_q    <= fdc_cmd_pkg::KIND_NONE;
            op_q      <= fdc_cmd_pkg::BYTE_RESET;
            prm_len_q <= 4'h0;
        end else if (op_taken) begin
            kind_q    <= dec_kind;                                                   // see R1
            op_q      <= i_cmd_byte;
            prm_len_q <= dec_prm_len;                                                // see R7
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            prm_idx_q <= 4'h0;
        end else if (op_taken) begin
            prm_idx_q <= 4'h0;
        end else if (in_param && cmd_take) begin
            prm_idx_q <= prm_idx_q + 4'h1;
        end
    end

    // parameter bytes land in arrival order: drive, c, h, r, n, last, gap, length
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            for (int i = 0; i < 8; i++) begin
                prm_q[i] <= fdc_cmd_pkg::BYTE_RESET;
            end
        end else if (in_param && cmd_take) begin
            prm_q[prm_idx_q[2:0]] <= i_cmd_byte;                                     // see R7
        end
    end

    // result bytes: status a, b, c then the id reached
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            for (int i = 0; i < 7; i++) begin
                res_q[i] <= fdc_cmd_pkg::BYTE_RESET;
            end
            res_len_q <= 3'h0;
        end else if (op_version) begin
            res_q[0]  <= fdc_cmd_pkg::VERSION_BYTE;                                  // see R10
            res_len_q <= fdc_cmd_pkg::RES_LEN_ONE;
        end else if (op_bad || drv_bad) begin
            res_q[0]  <= fdc_cmd_pkg::INVALID_BYTE;
            res_len_q <= fdc_cmd_pkg::RES_LEN_ONE;
        end else if (done_take) begin
            res_q[0]  <= i_result_status_a;                                          // see R2
            res_q[1]  <= i_result_status_b;                                          // see R8
            res_q[2]  <= i_result_status_c;
            res_q[3]  <= i_end_cylinder;
            res_q[4]  <= i_end_head;
            res_q[5]  <= i_end_record;
            res_q[6]  <= i_end_size_code;
            res_len_q <= fdc_cmd_pkg::RES_LEN_FULL;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            res_idx_q <= 3'h0;
        end else if (last_res) begin
            res_idx_q <= 3'h0;
        end else if (res_take) begin
            res_idx_q <= res_idx_q + 3'h1;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            start_q   <= 1'b0;
            invalid_q <= 1'b0;
        end else begin
            start_q   <= last_prm && !drv_bad;
            invalid_q <= op_bad || drv_bad;
        end
    end

    // host handshakes
    assign o_cmd_ready  = in_idle || in_param;
    assign o_res_valid  = (state_q == fdc_cmd_pkg::ST_RESULT);
    assign o_res_byte   = res_q[res_idx_q];
    assign o_cmd_invalid = invalid_q;

    // execution request, held steady while busy
    assign o_exec_start          = start_q;
    assign o_exec_busy           = in_exec;
    assign o_exec_kind           = kind_q;
    assign o_multitrack_flag     = op_q[fdc_cmd_pkg::BIT_MULTI] &&
                                   (kind_q != fdc_cmd_pkg::KIND_READ_ID);            // see R5
    assign o_double_density_flag = op_q[fdc_cmd_pkg::BIT_DENSITY];                  // see R1
    assign o_skip_deleted_flag   = op_q[fdc_cmd_pkg::BIT_SKIP] &&
                                   (kind_q == fdc_cmd_pkg::KIND_VERIFY);             // see R3
    assign o_count_enable_flag   = cnt_en_sel;
    assign o_deleted_mark        = (kind_q == fdc_cmd_pkg::KIND_WRITE_DEL);         // see R6
    assign o_head_select         = prm_q[0][fdc_cmd_pkg::BIT_HEAD];                 // see R9
    assign o_drive_num_hi        = prm_q[0][fdc_cmd_pkg::BIT_DRV_HI];
    assign o_drive_num_lo        = prm_q[0][fdc_cmd_pkg::BIT_DRV_LO];
    assign o_cylinder            = prm_q[1];
    assign o_head_addr           = prm_q[2];
    assign o_record              = prm_q[3];
    assign o_size_code           = prm_q[4];
    assign o_last_sector_number  = prm_q[5];
    assign o_gap_length_param    = prm_q[6];
    // length or sector count for verify, chosen by count-enable downstream
    assign o_data_length_param   = prm_q[7];                                         // see R4
    assign o_host_data_en        = data_path;

    // write stream passes straight through so the drive stalls the host
    assign o_drv_wr_valid = data_path && i_wr_valid;                                 // see R5
    assign o_drv_wr_byte  = i_wr_byte;
    assign o_wr_ready     = data_path && i_drv_wr_ready;                             // see R6
endmodule
`default_nettype wire

// file: logic/fdc_cmd_pkg.sv
// constants, opcode kinds and sequencer states of the floppy command sequencer
// assumes one clock domain and a byte-wide command/result port toward the host
// How it works
// R1 - read id opcode 0x001010, one drive byte
// R2 - read id returns three status, four id
// R3 - verify opcode with three flags and 10110
// R4 - verify moves no data, only checks
// R5 - write opcode 00101, host data to drive
// R6 - write deleted opcode 01001, deleted mark
// R7 - host sends seven id/length parameter bytes
// R8 - these commands return seven result bytes
// R9 - drive byte: head bit2, drive bits1:0
// R10 - version query returns one byte, no execution
package fdc_cmd_pkg;

    typedef enum logic [2:0] {
        KIND_NONE      = 3'b000,
        KIND_READ_ID   = 3'b001,
        KIND_VERIFY    = 3'b010,
        KIND_VERSION   = 3'b011,
        KIND_WRITE     = 3'b100,
        KIND_WRITE_DEL = 3'b101
    } cmd_kind_t;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_PARAM  = 3'b001,
        ST_START  = 3'b010,
        ST_EXEC   = 3'b011,
        ST_RESULT = 3'b100
    } seq_state_t;

    // opcode fields
    localparam logic [4:0] OP_READ_ID   = 5'h0A;
    localparam logic [4:0] OP_VERIFY    = 5'h16;
    localparam logic [4:0] OP_WRITE     = 5'h05;
    localparam logic [4:0] OP_WRITE_DEL = 5'h09;
    localparam logic [7:0] OP_VERSION   = 8'h10;
    localparam int         BIT_MULTI    = 7;
    localparam int         BIT_DENSITY  = 6;
    localparam int         BIT_SKIP     = 5;

    // drive byte fields
    localparam int         BIT_COUNT_EN = 7;
    localparam int         BIT_HEAD     = 2;
    localparam int         BIT_DRV_HI   = 1;
    localparam int         BIT_DRV_LO   = 0;
    localparam logic [7:0] DRV_RSVD_MASK = 8'h78;

    // byte counts
    localparam logic [3:0] PRM_LEN_SHORT = 4'h1;
    localparam logic [3:0] PRM_LEN_LONG  = 4'h8;
    localparam logic [2:0] RES_LEN_ONE   = 3'h1;
    localparam logic [2:0] RES_LEN_FULL  = 3'h7;

    // answers without execution
    localparam logic [7:0] VERSION_BYTE = 8'h90;
    localparam logic [7:0] INVALID_BYTE = 8'h80;
    localparam logic [7:0] BYTE_RESET   = 8'h00;

endpackage

// file: logic/fdc_opcode_decode.sv
// opcode decoder: first command byte to command kind and parameter count
// assumes the byte is stable while the sequencer samples it
`timescale 1ns/1ps
`default_nettype none
module fdc_opcode_decode (
    input  wire logic [7:0]             i_opcode,
    output fdc_cmd_pkg::cmd_kind_t      o_kind,
    output logic      [3:0]             o_prm_len
);
    wire logic [4:0] low5    = i_opcode[4:0];
    wire logic       bit7    = i_opcode[fdc_cmd_pkg::BIT_MULTI];
    wire logic       bit5    = i_opcode[fdc_cmd_pkg::BIT_SKIP];
    wire logic       is_rdid = (low5 == fdc_cmd_pkg::OP_READ_ID) && !bit7 && !bit5;   // see R1
    wire logic       is_vfy  = (low5 == fdc_cmd_pkg::OP_VERIFY);                      // see R3
    wire logic       is_wr   = (low5 == fdc_cmd_pkg::OP_WRITE) && !bit5;              // see R5
    wire logic       is_wrd  = (low5 == fdc_cmd_pkg::OP_WRITE_DEL) && !bit5;          // see R6
    wire logic       is_ver  = (i_opcode == fdc_cmd_pkg::OP_VERSION);                 // see R10

    assign o_kind = is_rdid ? fdc_cmd_pkg::KIND_READ_ID :
                    is_vfy  ? fdc_cmd_pkg::KIND_VERIFY :
                    is_wr   ? fdc_cmd_pkg::KIND_WRITE :
                    is_wrd  ? fdc_cmd_pkg::KIND_WRITE_DEL :
                    is_ver  ? fdc_cmd_pkg::KIND_VERSION :
                              fdc_cmd_pkg::KIND_NONE;

    // drive byte plus seven id and length bytes for the long commands
    assign o_prm_len = is_rdid ? fdc_cmd_pkg::PRM_LEN_SHORT :
                       (is_vfy || is_wr || is_wrd) ? fdc_cmd_pkg::PRM_LEN_LONG :   // see R7
                       4'h0;
endmodule
`default_nettype wire

// file: tb/fdc_drive_model.sv
// drive engine stand-in: answers each start with done after a set delay
// assumes it shares i_sys_clk and i_reset with the sequencer
`timescale 1ns/1ps
`default_nettype none
module fdc_drive_model (
    input  wire logic       i_sys_clk,
    input  wire logic       i_reset,
    input  wire logic       i_start,
    input  wire logic [7:0] i_wait,
    input  wire logic [2:0] i_sel,
    input  wire logic       i_del,
    input  wire logic [7:0] i_c, i_h, i_r, i_n,
    input  wire logic       i_wr_valid,
    output logic            o_wr_ready,
    output logic            o_done,
    output logic [7:0]      o_st_a, o_st_b, o_st_c, o_c, o_h, o_r, o_n,
    output logic [7:0]      o_wr_cnt
);
    logic [7:0] cnt_q;
    logic       run_q;
    logic       tog_q;
    // fields are only valid with done; otherwise the complement, so stale reads show
    assign o_st_a = o_done ? {5'h00, i_sel} : ~{5'h00, i_sel};
    assign o_st_b = o_done ? 8'h00 : 8'hFF;
    assign o_st_c = o_done ? {7'h00, i_del} : ~{7'h00, i_del};
    assign o_c = o_done ? i_c : ~i_c;
    assign o_h = o_done ? i_h : ~i_h;
    assign o_r = o_done ? i_r + 8'h01 : ~i_r;
    assign o_n = o_done ? i_n : ~i_n;
    // stalls every other cycle so the host stream must wait
    assign o_wr_ready = run_q & tog_q;
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            {cnt_q, run_q, tog_q, o_done, o_wr_cnt} <= '0;
        end else begin
            tog_q <= ~tog_q;
            o_done <= 1'b0;
            if (i_start) begin
                run_q <= 1'b1;
                cnt_q <= i_wait;
                o_wr_cnt <= 8'h00;
            end else if (run_q && cnt_q == 8'h00) begin
                run_q <= 1'b0;
                o_done <= 1'b1;
            end else if (run_q) begin
                cnt_q <= cnt_q - 8'h01;
            end
            if (i_wr_valid && o_wr_ready) o_wr_cnt <= o_wr_cnt + 8'h01;
        end
    end
endmodule
`default_nettype wire

// file: tb/fdc_cmd_seq_chk.sv
// checker on the sequencer ports: opcode decode, byte counts and handoffs
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module fdc_cmd_seq_chk (
    input wire logic       i_sys_clk, i_reset, i_cmd_valid, o_cmd_ready, o_res_valid,
    input wire logic       i_res_ready, i_wr_valid, o_wr_ready, o_exec_start, o_exec_busy,
    input wire logic       o_skip_deleted_flag, o_count_enable_flag, o_deleted_mark,
    input wire logic       o_head_select, o_drive_num_hi, o_drive_num_lo, o_host_data_en,
    input wire logic       o_drv_wr_valid, i_exec_done,
    input wire logic [7:0] i_cmd_byte, o_res_byte, i_wr_byte, o_drv_wr_byte,
    input wire logic [7:0] o_data_length_param, i_result_status_a,
    input wire fdc_cmd_pkg::cmd_kind_t o_exec_kind
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);
    logic       take, idle_q, long_q;
    logic [3:0] pcnt_q;
    logic [2:0] rcnt_q;
    logic [7:0] op_q, drv_q, last_q;
    assign take = i_cmd_valid && o_cmd_ready;
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            {idle_q, long_q, pcnt_q, rcnt_q} <= {1'b1, 8'h00};
        end else begin
            if (take) last_q <= i_cmd_byte;
            if (take && idle_q) {idle_q, op_q, pcnt_q, rcnt_q, long_q} <= {1'b0, i_cmd_byte, 8'h10};
            else if (take) pcnt_q <= pcnt_q + 4'h1;
            if (take && !idle_q && pcnt_q == 4'h1) drv_q <= i_cmd_byte;
            if (o_res_valid) idle_q <= 1'b1;
            if (o_res_valid && i_res_ready) rcnt_q <= rcnt_q + 3'h1;
            if (o_exec_start) long_q <= 1'b1;
        end
    end
    sequence s_opc(logic [7:0] v);
        idle_q && take && (i_cmd_byte & 8'hBF) == v;
    endsequence
    sequence s_rid;
        s_opc(8'h0A) ##1 take && (i_cmd_byte & 8'h78) == 8'h00;
    endsequence
    property p_rid; s_rid |-> ##1 o_exec_start && o_exec_kind == fdc_cmd_pkg::KIND_READ_ID; endproperty
    a_rid: assert property (p_rid) else $error("read id start missing");
    property p_ver; s_opc(8'h10) |=> o_res_valid && o_res_byte == 8'h90 && !o_exec_busy; endproperty
    a_ver: assert property (p_ver) else $error("version answer wrong");
    property p_cnt; $fell(o_res_valid) |-> rcnt_q == (long_q ? 3'h7 : 3'h1); endproperty
    a_cnt: assert property (p_cnt) else $error("result byte count wrong");
    property p_done; o_exec_busy && i_exec_done |=> o_res_valid && !o_exec_busy
        && o_res_byte == $past(i_result_status_a); endproperty
    a_done: assert property (p_done) else $error("first result byte wrong");
    property p_drv; o_exec_start |-> {o_head_select, o_drive_num_hi, o_drive_num_lo}
        == drv_q[2:0] && !o_exec_busy ##1 o_exec_busy && !o_exec_start; endproperty
    a_drv: assert property (p_drv) else $error("drive select wrong");
    property p_vfy; o_exec_start && op_q[4:0] == 5'h16 |-> o_skip_deleted_flag == op_q[5]
        && o_count_enable_flag == drv_q[7] && o_data_length_param == last_q; endproperty
    a_vfy: assert property (p_vfy) else $error("verify fields wrong");
    property p_nodata; o_exec_busy && o_exec_kind == fdc_cmd_pkg::KIND_VERIFY
        |-> !o_host_data_en && !o_drv_wr_valid && !o_wr_ready; endproperty
    a_nodata: assert property (p_nodata) else $error("verify moved data");
    property p_wr; o_exec_start && (op_q & 8'h3F) == 8'h05 |-> !o_deleted_mark
        && o_exec_kind == fdc_cmd_pkg::KIND_WRITE && o_data_length_param == last_q; endproperty
    a_wr: assert property (p_wr) else $error("write decode wrong");
    property p_wrd; o_exec_start && (op_q & 8'h3F) == 8'h09 |-> o_deleted_mark
        && o_exec_kind == fdc_cmd_pkg::KIND_WRITE_DEL; endproperty
    a_wrd: assert property (p_wrd) else $error("write deleted decode wrong");
    property p_pass; o_host_data_en && i_wr_valid |-> o_drv_wr_valid
        && o_drv_wr_byte == i_wr_byte; endproperty
    a_pass: assert property (p_pass) else $error("write data not passed");
endmodule
bind fdc_cmd_seq fdc_cmd_seq_chk i_chk (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
    .i_cmd_valid(i_cmd_valid), .o_cmd_ready(o_cmd_ready), .o_res_valid(o_res_valid),
    .i_res_ready(i_res_ready), .i_wr_valid(i_wr_valid), .o_wr_ready(o_wr_ready),
    .o_exec_start(o_exec_start), .o_exec_busy(o_exec_busy), .o_deleted_mark(o_deleted_mark),
    .o_skip_deleted_flag(o_skip_deleted_flag), .o_count_enable_flag(o_count_enable_flag),
    .o_head_select(o_head_select), .o_drive_num_hi(o_drive_num_hi), .i_exec_done(i_exec_done),
    .o_drive_num_lo(o_drive_num_lo), .o_host_data_en(o_host_data_en), .i_wr_byte(i_wr_byte),
    .o_drv_wr_valid(o_drv_wr_valid), .i_cmd_byte(i_cmd_byte), .o_res_byte(o_res_byte),
    .o_drv_wr_byte(o_drv_wr_byte), .o_data_length_param(o_data_length_param),
    .i_result_status_a(i_result_status_a), .o_exec_kind(o_exec_kind));
`default_nettype wire

// file: tb/fdc_read_id_verify_write_cmds_tb.sv
// bench for the command sequencer: host byte tasks against a drive engine stand-in
// assumes the checker binds itself into the sequencer
`timescale 1ns/1ps
`default_nettype none
module fdc_read_id_verify_write_cmds_tb;
    logic clk = 0, rst = 1, cv = 0, rr = 0, wv = 0;
    logic [7:0] cb = 8'h00, wb = 8'h00, wt = 8'h02, rb, sa, sb, sc, ec, eh, er, en, wcnt, dwb;
    logic [7:0] cyl, hd, rec, sz, lst, gap, data_length_param;
    logic start, busy, cready, rv, done, dwr, dwv, wrdy, inv, mt, dd, sk, ce, dm, hs, d1, d0, hde;
    fdc_cmd_pkg::cmd_kind_t kind;
    logic [7:0] p [0:6] = '{default: 8'h00};
    int mismatches = 0, compares = 0;
    always #12.5 clk = ~clk;
    fdc_cmd_seq i_dut (.i_sys_clk(clk), .i_reset(rst), .i_cmd_valid(cv), .i_cmd_byte(cb),
        .o_cmd_ready(cready), .o_res_valid(rv), .o_res_byte(rb), .i_res_ready(rr),
        .i_wr_valid(wv), .i_wr_byte(wb), .o_wr_ready(wrdy), .o_exec_start(start),
        .o_exec_busy(busy), .o_exec_kind(kind), .o_multitrack_flag(mt),
        .o_double_density_flag(dd), .o_skip_deleted_flag(sk), .o_count_enable_flag(ce),
        .o_deleted_mark(dm), .o_head_select(hs), .o_drive_num_hi(d1), .o_drive_num_lo(d0),
        .o_cylinder(cyl), .o_head_addr(hd), .o_record(rec), .o_size_code(sz),
        .o_last_sector_number(lst), .o_gap_length_param(gap), .o_data_length_param(data_length_param),
        .o_host_data_en(hde), .o_drv_wr_valid(dwv), .o_drv_wr_byte(dwb),
        .i_drv_wr_ready(dwr), .i_exec_done(done), .i_result_status_a(sa),
        .i_result_status_b(sb), .i_result_status_c(sc), .i_end_cylinder(ec),
        .i_end_head(eh), .i_end_record(er), .i_end_size_code(en), .o_cmd_invalid(inv));
    fdc_drive_model i_drv (.i_sys_clk(clk), .i_reset(rst), .i_start(start), .i_wait(wt),
        .i_sel({hs, d1, d0}), .i_del(dm), .i_c(cyl), .i_h(hd), .i_r(rec), .i_n(sz),
        .i_wr_valid(dwv), .o_wr_ready(dwr), .o_done(done), .o_st_a(sa), .o_st_b(sb),
        .o_st_c(sc), .o_c(ec), .o_h(eh), .o_r(er), .o_n(en), .o_wr_cnt(wcnt));
    task automatic summarize();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // every wait is bounded; running out ends the run
    task automatic wait_for(input int s);
        int n = 0;
        while ((s == 0 ? cready : s == 1 ? rv : s == 2 ? start : wrdy) !== 1'b1) begin
            @(negedge clk);
            n++;
            if (n > 200) begin
                mismatches++;
                $display("ERROR %0t: timeout waiting on %0d", $time, s);
                summarize();
            end
        end
    endtask
    task automatic put(input logic [7:0] b);
        cv = 1'b1;
        cb = b;
        wait_for(0);
        @(negedge clk);
    endtask
    task automatic get(input logic [7:0] e);
        rr = 1'b1;
        wait_for(1);
        chk(rb, e);
        @(negedge clk);
    endtask
    task automatic cmd(input logic [7:0] op, input logic [7:0] dr, input int np);
        put(op);
        put(dr);
        for (int i = 0; i < np; i++) put(p[i]);
        cv = 1'b0;
        wait_for(2);
        // start leads busy by one cycle; look at the request once busy
        @(negedge clk);
    endtask
    task automatic res7(input logic [7:0] dr, input logic del);
        get({5'h00, dr[2:0]});
        get(8'h00);
        get({7'h00, del});
        get(p[0]);
        get(p[1]);
        get(p[2] + 8'h01);
        get(p[3]);
        rr = 1'b0;
        chk({rv, cready}, 2'b01);
    endtask
    initial begin
        repeat (16) @(negedge clk);
        rst = 1'b0;
        put(8'h10);
        cv = 1'b0;
        get(8'h90);
        rr = 1'b0;
        chk({rv, busy}, 2'b00);
        $display("test version done");
        cmd(8'h4A, 8'h05, 0);
        chk({kind, dd, hs, d1, d0}, {fdc_cmd_pkg::KIND_READ_ID, 4'b1101});
        res7(8'h05, 1'b0);
        $display("test read id done");
        wt = 8'h14;
        p = '{8'h12, 8'h01, 8'h03, 8'h02, 8'h09, 8'h1B, 8'hFF};
        wv = 1'b1;
        wb = 8'h5A;
        cmd(8'hF6, 8'h86, 7);
        chk({kind, mt, dd, sk, ce}, {fdc_cmd_pkg::KIND_VERIFY, 4'hF});
        chk({cyl, hd, rec, sz, lst, gap, data_length_param}, {p[0], p[1], p[2], p[3], p[4], p[5], p[6]});
        repeat (3) @(negedge clk);
        chk({hde, dwv, wrdy}, 3'b000);
        wv = 1'b0;
        res7(8'h86, 1'b0);
        $display("test verify done");
        p = '{8'h27, 8'h00, 8'h11, 8'h03, 8'h12, 8'h2A, 8'h80};
        cmd(8'h45, 8'h02, 7);
        chk({kind, mt, dd, dm, hde}, {fdc_cmd_pkg::KIND_WRITE, 4'b0101});
        for (int k = 0; k < 4; k++) begin
            wv = 1'b1;
            wb = 8'hA0 + 8'(k);
            wait_for(3);
            @(negedge clk);
        end
        wv = 1'b0;
        chk(wcnt, 8'h04);
        res7(8'h02, 1'b0);
        $display("test write done");
        wt = 8'h02;
        cmd(8'hC9, 8'h03, 7);
        chk({kind, mt, dm}, {fdc_cmd_pkg::KIND_WRITE_DEL, 2'b11});
        res7(8'h03, 1'b1);
        $display("test write deleted done");
        // refused opcodes: unknown, read id with bit7, write with bit5
        foreach (p[i]) if (i < 3) begin
            put(i == 0 ? 8'h00 : i == 1 ? 8'hCA : 8'h65);
            chk(inv, 1'b1);
            cv = 1'b0;
            get(8'h80);
            rr = 1'b0;
            chk({rv, busy}, 2'b00);
        end
        put(8'h45);
        put(8'h0D);
        chk(inv, 1'b1);
        cv = 1'b0;
        get(8'h80);
        rr = 1'b0;
        chk({rv, cready, busy}, 3'b010);
        $display("test refusals done");
        summarize();
    end
endmodule
`default_nettype wire
